// ### common/mw_frame_pkg.sv
// constants and types shared by the half-duplex command frame master
package mw_frame_pkg;

   // ****************************************************************
   // frame layout
   // ****************************************************************
   localparam int CMD_BITS = 8;
   localparam int TURN_BITS = 1;
   localparam int REPLY_MIN_BITS = 4;
   localparam int REPLY_MAX_BITS = 16;
   localparam int WORD_W = REPLY_MAX_BITS;
   localparam int LEN_W = 4;
   localparam logic [LEN_W-1:0] REPLY_MIN_M1 = 4'h3;
   localparam logic [4:0] CMD_LAST_BIT = 5'h07;

   // ****************************************************************
   // buffering
   // ****************************************************************
   localparam int FIFO_DEPTH = 16;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int SYS_CLK_PERIOD_NS = 8;
   localparam int SCK_PERIOD_NS = 128;
   localparam int SCK_HALF_NS = SCK_PERIOD_NS / 2;
   // half period rounded up to whole system cycles, at least one
   localparam int SCK_HALF_CYC_I = (SCK_HALF_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
   localparam int SCK_HALF_CYC = (SCK_HALF_CYC_I < 1) ? 1 : SCK_HALF_CYC_I;
   localparam int HALF_CNT_W = 5;
   localparam logic [HALF_CNT_W-1:0] HALF_LAST = HALF_CNT_W'(SCK_HALF_CYC - 1);

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic SCK_IDLE = 1'b0;
   localparam logic FSEL_IDLE_N = 1'b1;
   localparam logic SDO_IDLE = 1'b0;

   // ****************************************************************
   // frame states
   // ****************************************************************
   typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_TURN, ST_REPLY, ST_GAP} frame_state_e;

endpackage

// ### common/word_stream_if.sv
// valid/ready word stream between the frame engine and its reply buffer
`timescale 1ns/1ps
interface word_stream_if #(parameter int W = 16);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ### logic/bit_sync.sv
// two-stage synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module bit_sync
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // level in and out
   input wire logic d,
   output logic q
);
   logic meta_r;
   logic q_r;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta_r <= 1'b0;
         q_r <= 1'b0;
      end
      else
      begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end

   assign q = q_r;
endmodule // bit_sync

// ### logic/reply_fifo.sv
// reply word buffer with registered output stage
`timescale 1ns/1ps
module reply_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // fill side
   word_stream_if.snk wr,
   // drain side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic out_valid_r;
   logic [WIDTH-1:0] out_data_r;
   logic push;
   logic pop;

   assign wr.ready = (count_r != (AW+1)'(DEPTH));
   assign push = wr.valid && wr.ready;
   // move a word to the output stage whenever it is empty or being taken
   assign pop = (count_r != '0) && (!out_valid_r || out_ready);

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr_r] <= wr.data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
         end
         if (pop)
         begin
            rd_ptr_r <= AW'(rd_ptr_r + 1'b1);
         end
         count_r <= (AW+1)'(count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         out_valid_r <= 1'b0;
         out_data_r <= '0;
      end
      else if (pop)
      begin
         out_valid_r <= 1'b1;
         out_data_r <= mem[rd_ptr_r];
      end
      else if (out_ready)
      begin
         out_valid_r <= 1'b0;
      end
   end

   assign out_valid = out_valid_r;
   assign out_data = out_data_r;
endmodule // reply_fifo

// ### logic/mw_frame_master.sv
// half-duplex command/response serial frame master
`timescale 1ns/1ps

module mw_frame_master
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // command request
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [mw_frame_pkg::CMD_BITS-1:0] cmd_data,
   input wire logic [mw_frame_pkg::LEN_W-1:0] reply_bits_m1,
   // reply words
   output logic reply_valid,
   output logic [mw_frame_pkg::WORD_W-1:0] reply_data,
   input wire logic reply_ready,
   // serial link
   output logic serial_shift_clock,
   output logic frame_select_n,
   output logic serial_out,
   input wire logic serial_in
);
   import mw_frame_pkg::*;

   // ****************************************************************
   // state
   // ****************************************************************
   frame_state_e state_r;
   logic [HALF_CNT_W-1:0] half_cnt_r;
   logic [4:0] bit_cnt_r;
   logic [CMD_BITS-1:0] tx_r;
   logic [WORD_W-1:0] rx_r;
   logic [LEN_W-1:0] len_r;
   logic sck_r;
   logic fsel_n_r;
   logic sdo_r;
   logic cmd_ready_r;
   logic push_r;
   logic [WORD_W-1:0] push_data_r;
   logic sdi_sync;
   logic half_done;
   logic in_bits;
   logic rise_ev;
   logic fall_ev;
   logic take;
   logic reply_last;

   word_stream_if #(.W(WORD_W)) rply ();

   // ****************************************************************
   // input synchroniser and reply buffer
   // ****************************************************************
   bit_sync u_sdi_sync
   (
      .clk(clk),
      .rst(rst),
      .d(serial_in),
      .q(sdi_sync)
   );

   reply_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_reply_fifo
   (
      .clk(clk),
      .rst(rst),
      .wr(rply.snk),
      .out_valid(reply_valid),
      .out_data(reply_data),
      .out_ready(reply_ready)
   );

   assign rply.valid = push_r;
   assign rply.data = push_data_r;

   // ****************************************************************
   // serial clock timing
   // ****************************************************************
   assign in_bits = (state_r == ST_CMD) || (state_r == ST_TURN) || (state_r == ST_REPLY);
   assign half_done = (half_cnt_r == HALF_LAST);
   assign rise_ev = in_bits && half_done && !sck_r;
   assign fall_ev = in_bits && half_done && sck_r;
   assign take = (state_r == ST_IDLE) && cmd_valid && cmd_ready_r;
   // falling edge that ends the last reply bit closes the frame
   assign reply_last = (state_r == ST_REPLY) && fall_ev && (bit_cnt_r == {1'b0, len_r});

   always_ff @(posedge clk)
   begin
      // the count rests at zero between frames, so the first half period is full length
      if (rst || state_r == ST_IDLE)
      begin
         half_cnt_r <= '0;
      end
      else if (half_done)
      begin
         half_cnt_r <= '0;
      end
      else
      begin
         half_cnt_r <= HALF_CNT_W'(half_cnt_r + 1'b1);
      end
   end

   // each bit period is a low half then a high half
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sck_r <= SCK_IDLE;
      end
      else if (in_bits && half_done)
      begin
         sck_r <= !sck_r;
      end
      else if (!in_bits)
      begin
         sck_r <= SCK_IDLE;
      end
   end

   // ****************************************************************
   // frame sequencer
   // ****************************************************************
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_r <= ST_IDLE;
         bit_cnt_r <= '0;
      end
      else
      begin
         unique case (state_r)
            ST_IDLE:
            begin
               if (take)
               begin
                  state_r <= ST_CMD;
                  bit_cnt_r <= '0;
               end
            end
            ST_CMD:
            begin
               if (fall_ev)
               begin
                  if (bit_cnt_r == CMD_LAST_BIT)
                  begin
                     state_r <= ST_TURN;
                     bit_cnt_r <= '0;
                  end
                  else
                  begin
                     bit_cnt_r <= 5'(bit_cnt_r + 1'b1);
                  end
               end
            end
            ST_TURN:
            begin
               if (fall_ev)
               begin
                  state_r <= ST_REPLY;
               end
            end
            ST_REPLY:
            begin
               if (fall_ev)
               begin
                  if (bit_cnt_r == {1'b0, len_r})
                  begin
                     state_r <= ST_GAP;
                  end
                  else
                  begin
                     bit_cnt_r <= 5'(bit_cnt_r + 1'b1);
                  end
               end
            end
            ST_GAP:
            begin
               // frame select stays high a half period before the next frame
               if (half_done)
               begin
                  state_r <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // reply length is latched when a command is taken and held for the whole frame
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         len_r <= REPLY_MIN_M1;
      end
      else if (take)
      begin
         // shorter replies than the minimum are stretched to it
         len_r <= (reply_bits_m1 < REPLY_MIN_M1) ? REPLY_MIN_M1 : reply_bits_m1;
      end
   end

   // ****************************************************************
   // frame select and command shifter
   // ****************************************************************
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         fsel_n_r <= FSEL_IDLE_N;
      end
      else if (take)
      begin
         fsel_n_r <= 1'b0;
      end
      else if (reply_last)
      begin
         fsel_n_r <= FSEL_IDLE_N;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         tx_r <= '0;
         sdo_r <= SDO_IDLE;
      end
      else if (take)
      begin
         tx_r <= {cmd_data[CMD_BITS-2:0], 1'b0};
         sdo_r <= cmd_data[CMD_BITS-1];
      end
      else if (state_r == ST_CMD && fall_ev)
      begin
         // last command bit leaves the line low for the turnaround
         tx_r <= {tx_r[CMD_BITS-2:0], 1'b0};
         sdo_r <= (bit_cnt_r == CMD_LAST_BIT) ? SDO_IDLE : tx_r[CMD_BITS-1];
      end
   end

   // ****************************************************************
   // reply capture
   // ****************************************************************
   always_ff @(posedge clk)
   begin
      if (rst || take)
      begin
         rx_r <= '0;
      end
      else if (state_r == ST_REPLY && rise_ev)
      begin
         // the synchronised input lags the pin by two cycles, far inside the half period
         // only the reply phase samples; command and turnaround bits are ignored
         rx_r <= {rx_r[WORD_W-2:0], sdi_sync};
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         push_r <= 1'b0;
         push_data_r <= '0;
      end
      else
      begin
         push_r <= reply_last;
         push_data_r <= rx_r;
      end
   end

   // ****************************************************************
   // command handshake
   // ****************************************************************
   // a frame starts only when its reply is sure to find room in the buffer
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cmd_ready_r <= 1'b0;
      end
      else
      begin
         cmd_ready_r <= (state_r == ST_IDLE) && !take && !push_r && rply.ready;
      end
   end

   assign serial_shift_clock = sck_r;
   assign frame_select_n = fsel_n_r;
   assign serial_out = sdo_r;
   assign cmd_ready = cmd_ready_r;
endmodule // mw_frame_master

// ### testbench/mw_frame_props.sv
// assertions on the frame master's ports
`timescale 1ns/1ps
module mw_frame_props
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // command request
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic [mw_frame_pkg::CMD_BITS-1:0] cmd_data,
   // serial link
   input wire logic serial_shift_clock,
   input wire logic frame_select_n,
   input wire logic serial_out
);
   import mw_frame_pkg::*;
   logic [9:0] low_cnt_r;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // cycles spent with the frame select low
   always_ff @(posedge clk)
   begin
      if (rst || frame_select_n)
         low_cnt_r <= 10'h000;
      else
         low_cnt_r <= low_cnt_r + 10'h001;
   end
   chk_idle_clock_low: assert property (frame_select_n |-> !serial_shift_clock)
      else $error("serial clock high outside a frame");
   chk_frame_start: assert property (cmd_valid && cmd_ready |=> !frame_select_n && !cmd_ready)
      else $error("taken command did not open a frame");
   chk_msb_first: assert property (cmd_valid && cmd_ready |=> serial_out == $past(cmd_data[CMD_BITS-1]))
      else $error("first command bit is not the msb");
   chk_out_on_fall: assert property ($changed(serial_out) |-> $fell(serial_shift_clock) || $fell(frame_select_n))
      else $error("serial out changed off a falling clock edge");
   chk_sck_high_half: assert property ($rose(serial_shift_clock) |=> serial_shift_clock [*7] ##1 !serial_shift_clock)
      else $error("serial clock high phase wrong");
   chk_sck_low_half: assert property ($fell(serial_shift_clock) && !frame_select_n |=> !serial_shift_clock [*7] ##1
      serial_shift_clock)
      else $error("serial clock stopped inside a frame");
   chk_frame_gap: assert property ($rose(frame_select_n) |=> frame_select_n [*7])
      else $error("frame select gap too short");
   chk_frame_len: assert property ($rose(frame_select_n) |-> low_cnt_r >= 10'h0d0 && low_cnt_r <= 10'h190 &&
      low_cnt_r[3:0] == 4'h0)
      else $error("frame length not 13 to 25 serial periods");
   chk_busy_frame: assert property (!frame_select_n |-> !cmd_ready)
      else $error("command ready during a frame");
endmodule // mw_frame_props

// ### testbench/serial_slave_model.sv
// behavioural serial slave answering command frames
`timescale 1ns/1ps
module serial_slave_model
(
   // serial link
   input wire logic serial_shift_clock,
   input wire logic frame_select_n,
   input wire logic serial_out,
   output logic serial_in,
   // reply setup and observed command
   input wire logic [15:0] reply_word,
   input wire logic [4:0] reply_len,
   output logic [7:0] cmd_seen
);
   int falls = 0;
   initial serial_in = 1'b0;
   always @(negedge frame_select_n)
   begin
      falls = 0;
      cmd_seen = 8'h00;
   end
   // command captured on rising edges, msb first
   always @(posedge serial_shift_clock)
      if (frame_select_n === 1'b0 && falls < 8)
         cmd_seen = {cmd_seen[6:0], serial_out};
   // reply after one idle period, changed on falling edges
   always @(negedge serial_shift_clock)
   begin
      falls++;
      if (falls >= 9 && falls - 9 < reply_len)
         serial_in = reply_word[reply_len - 1 - (falls - 9)];
      else
         serial_in = ~serial_in;
   end
   // released line carries no stable level
   always #13 if (frame_select_n !== 1'b0) serial_in = ~serial_in;
endmodule // serial_slave_model

// ### testbench/tb_top.sv
// testbench for the command frame master
`timescale 1ns/1ps
module tb_top;
   import mw_frame_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cmd_valid = 1'b0;
   logic reply_ready = 1'b0;
   logic hold = 1'b0;
   logic [CMD_BITS-1:0] cmd_data = 8'h00;
   logic [LEN_W-1:0] reply_bits_m1 = 4'h0;
   logic [WORD_W-1:0] slave_word = 16'h0000;
   logic [4:0] slave_len = 5'h04;
   logic cmd_ready, reply_valid, serial_shift_clock, frame_select_n, serial_out, serial_in;
   logic [WORD_W-1:0] reply_data;
   logic [7:0] cmd_seen;
   int error_cnt = 0;
   int tests_run = 0;
   int seed = 32'h1233b5e0;
   int exp_q[$];
   int cmd_q[$];

   mw_frame_master dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_data(cmd_data),
      .reply_bits_m1(reply_bits_m1), .reply_valid(reply_valid), .reply_data(reply_data), .reply_ready(reply_ready),
      .serial_shift_clock(serial_shift_clock), .frame_select_n(frame_select_n), .serial_out(serial_out),
      .serial_in(serial_in));
   serial_slave_model slave (.serial_shift_clock(serial_shift_clock), .frame_select_n(frame_select_n),
      .serial_out(serial_out), .serial_in(serial_in), .reply_word(slave_word), .reply_len(slave_len),
      .cmd_seen(cmd_seen));

   initial forever #4 clk = ~clk;

   task automatic check_reply(input logic [WORD_W-1:0] exp, input logic [WORD_W-1:0] got);
      tests_run++;
      if (got !== exp)
      begin
         $display("BAD reply expected %h seen %h", exp, got);
         error_cnt++;
      end
   endtask

   task automatic check_cmd(input logic [CMD_BITS-1:0] exp, input logic [CMD_BITS-1:0] got);
      tests_run++;
      if (got !== exp)
      begin
         $display("BAD command expected %h seen %h", exp, got);
         error_cnt++;
      end
   endtask

   task automatic check_ready(input logic exp, input logic got);
      tests_run++;
      if (got !== exp)
      begin
         $display("BAD cmd_ready expected %h seen %h", exp, got);
         error_cnt++;
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // one command; the model expects a clamped reply length
   task automatic send(input logic [3:0] m1);
      int n;
      int i;
      n = (m1 < 4'h3) ? 4 : int'(m1) + 1;
      @(negedge clk);
      cmd_data = 8'($random(seed));
      reply_bits_m1 = m1;
      cmd_valid = 1'b1;
      for (i = 0; cmd_ready !== 1'b1; i++)
      begin
         if (i > 3000)
         begin
            error_cnt++;
            summarize();
         end
         @(negedge clk);
      end
      slave_word = 16'($random(seed));
      slave_len = 5'(n);
      exp_q.push_back(int'(slave_word) & ((1 << n) - 1));
      cmd_q.push_back(int'(cmd_data));
      @(negedge clk);
      cmd_valid = 1'b0;
   endtask

   task automatic drain();
      int i;
      for (i = 0; exp_q.size() > 0; i++)
      begin
         if (i > 20000)
         begin
            error_cnt++;
            summarize();
         end
         @(negedge clk);
      end
   endtask

   // reply consumer with random stalls; a word is checked while it waits for the edge that takes it
   always @(negedge clk)
   begin
      reply_ready = hold ? 1'b0 : 1'($random(seed));
      if (reply_valid === 1'b1 && reply_ready === 1'b1)
         check_reply(exp_q.size() ? 16'(exp_q.pop_front()) : 16'hxxxx, reply_data);
   end

   always @(posedge frame_select_n)
      if (cmd_q.size() > 0)
         check_cmd(8'(cmd_q.pop_front()), cmd_seen);

   initial
   begin
      int i;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      for (i = 0; i < 16; i++)
         send(4'(i));
      drain();
      hold = 1'b1;
      repeat (17) send(4'($random(seed)));
      repeat (600) @(negedge clk);
      check_ready(1'b0, cmd_ready);
      hold = 1'b0;
      repeat (3) send(4'hf);
      drain();
      summarize();
   end
endmodule // tb_top

bind mw_frame_master mw_frame_props u_props (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
   .cmd_data(cmd_data), .serial_shift_clock(serial_shift_clock), .frame_select_n(frame_select_n),
   .serial_out(serial_out));
